// ---- bench/test_txcrb_bank.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_txcrb_bank;
  logic clk, resetn, power_off_pin_n, transmit_gate_pin, pll_lock_raw, sclk, cs_n, sdata, lock_pin;
  txcrb_pkg::txcrb_serial_t pins;
  txcrb_pkg::txcrb_ctrl_t ctrl;
  logic [13:0] main_div;
  logic [10:0] ref_div;
  logic [7:0] test_reg;
  logic [16:0] rnd;
  logic [15:0] op, su, mn;
  logic [2:0] note_sel[$];
  logic [15:0] note_val[$];
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int i;
  event settle_ev;
  assign pins = {sclk, cs_n, sdata};
  txcrb_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .data(sdata));
  txcrb_bank uut (.clk(clk), .resetn(resetn), .serial_pins(pins), .power_off_pin_n(power_off_pin_n),
    .transmit_gate_pin(transmit_gate_pin), .pll_lock_raw(pll_lock_raw), .ctrl(ctrl), .if_main_divider(main_div),
    .if_reference_divider(ref_div), .test_control(test_reg), .lock_pin(lock_pin));
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  function automatic logic [15:0] fields(input logic [15:0] o, input logic [15:0] s);
    return {4'h0, o[8:3], s[12:8], s[5]};
  endfunction
  function automatic logic [15:0] band(input logic [15:0] o);
    return {11'h000, o[15], !o[15], o[12:11] == 2'h0, o[12:11] <= 2'h1, o[12:11] == 2'h3};
  endfunction
  function automatic logic [15:0] observe(input logic [2:0] sel);
    case (sel)
      3'h0: return {2'h0, main_div};
      3'h1: return {5'h00, ref_div};
      3'h2: return {8'h00, test_reg};
      3'h3: return {4'h0, ctrl.if_gain_trim, ctrl.upper_sideband, ctrl.if_lo_buffer_en, ctrl.quadrature_mod,
        ctrl.baseband_level, ctrl.lo_div2, ctrl.external_osc_select, ctrl.charge_pump_current, ctrl.detector_polarity};
      3'h4: return {11'h000, ctrl.lo_low_band_input, ctrl.lo_high_band_input, ctrl.fm_mode, ctrl.low_band_driver,
        ctrl.high_band_driver};
      3'h6: return {13'h0000, ctrl.charge_pump_boost, ctrl.if_vco_en, ctrl.bias_en};
      default: return {13'h0000, ctrl.modulator_en, ctrl.if_pll_en, lock_pin};
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic note(input logic [2:0] sel, input logic [15:0] val);
    note_sel.push_back(sel);
    note_val.push_back(val);
  endtask
  task automatic wr(input logic [15:0] d, input txcrb_pkg::txcrb_addr_t a);
    @(posedge clk);
    host.send({4'h0, d, a});
    repeat (8) @(posedge clk);
  endtask
  task automatic settle(input string name);
    #1;
    -> settle_ev;
    #1;
    $display("test %s done", name);
    @(posedge clk);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(settle_ev) begin
    while (note_val.size() > 0) begin
      check(observe(note_sel.pop_front()), note_val.pop_front());
    end
  end
  // Ceiling well above the expected 15k cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    power_off_pin_n = 1'b1;
    transmit_gate_pin = 1'b1;
    pll_lock_raw = 1'b1;
    rnd = 17'h14D74;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    note(3'h0, 16'h1977);
    note(3'h1, 16'h01EC);
    note(3'h3, fields(16'h892F, 16'hD03F));
    note(3'h5, 16'h0007);
    note(3'h6, 16'h0003);
    settle("power-up");
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      mn = {2'h0, rnd[13:0]};
      op = {rnd[16], 1'b0, rnd[15], i[1], i[1] ^ i[0], 2'h0, rnd[8:3], 3'h7};
      su = {3'h6, rnd[12:10], i[1:0], 2'h0, rnd[9], 5'h1D};
      wr(mn, txcrb_pkg::ADDR_MAIN_DIV);
      wr({5'h00, rnd[16:6]}, txcrb_pkg::ADDR_REF_DIV);
      wr({8'h00, rnd[7:0]}, txcrb_pkg::ADDR_TEST);
      wr(op, txcrb_pkg::ADDR_OP_CTRL);
      wr(su, txcrb_pkg::ADDR_SETUP);
      note(3'h0, mn);
      note(3'h1, {5'h00, rnd[16:6]});
      note(3'h2, {8'h00, rnd[7:0]});
      note(3'h3, fields(op, su));
      note(3'h4, band(op));
      note(3'h6, {13'h0000, rnd[15], !rnd[10], 1'b1});
      settle("random writes");
    end
    wr(16'hFFFF, 4'h6);
    wr(16'hFFFF, 4'hF);
    note(3'h0, mn);
    note(3'h4, band(op));
    settle("unmapped");
    op = 16'h890F;
    wr(op, txcrb_pkg::ADDR_OP_CTRL);
    wr(16'h903D, txcrb_pkg::ADDR_SETUP);
    wr(op & 16'hFFFD, txcrb_pkg::ADDR_OP_CTRL);
    note(3'h5, 16'h0003);
    note(3'h0, mn);
    settle("tx standby");
    wr(op & 16'hFFFB, txcrb_pkg::ADDR_OP_CTRL);
    note(3'h5, 16'h0000);
    note(3'h6, 16'h0001);
    note(3'h0, mn);
    settle("standby");
    wr(op, txcrb_pkg::ADDR_OP_CTRL);
    transmit_gate_pin <= 1'b0;
    repeat (8) @(posedge clk);
    note(3'h5, 16'h0003);
    settle("gate pin");
    transmit_gate_pin <= 1'b1;
    wr(16'h103D, txcrb_pkg::ADDR_SETUP);
    note(3'h5, 16'h0004);
    note(3'h6, 16'h0003);
    settle("pll off");
    pll_lock_raw <= 1'b0;
    wr(16'h903C, txcrb_pkg::ADDR_SETUP);
    for (i = 1; i >= 0; i--) begin
      wr(16'(i), txcrb_pkg::ADDR_TEST);
      note(3'h5, 16'h0006 | 16'(i));
      note(3'h6, 16'h0007);
      settle("test mode");
    end
    wr(16'h903D, txcrb_pkg::ADDR_SETUP);
    wr(16'h00AA, txcrb_pkg::ADDR_TEST);
    wr(op & 16'hFFFE, txcrb_pkg::ADDR_OP_CTRL);
    wr(16'h0456, txcrb_pkg::ADDR_MAIN_DIV);
    note(3'h0, 16'h1977);
    note(3'h2, 16'h0000);
    note(3'h6, 16'h0000);
    settle("soft shutdown");
    wr(op, txcrb_pkg::ADDR_OP_CTRL);
    wr(16'h0456, txcrb_pkg::ADDR_MAIN_DIV);
    wr(16'h190F, txcrb_pkg::ADDR_OP_CTRL);
    note(3'h0, 16'h0456);
    settle("wake");
    power_off_pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    power_off_pin_n <= 1'b1;
    repeat (20) @(posedge clk);
    note(3'h0, 16'h1977);
    note(3'h4, band(16'h892F));
    settle("pin shutdown");
    complete_run();
  end
endmodule
bind txcrb_bank txcrb_bank_chk chk (.clk(clk), .resetn(resetn), .serial_pins(serial_pins),
  .power_off_pin_n(power_off_pin_n), .transmit_gate_pin(transmit_gate_pin), .pll_lock_raw(pll_lock_raw),
  .ctrl(ctrl), .if_main_divider(if_main_divider), .if_reference_divider(if_reference_divider),
  .test_control(test_control), .lock_pin(lock_pin));
`default_nettype wire

// ---- bench/txcrb_bank_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module txcrb_bank_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire txcrb_pkg::txcrb_serial_t serial_pins,
  input wire logic power_off_pin_n,
  input wire logic transmit_gate_pin,
  input wire logic pll_lock_raw,
  input wire txcrb_pkg::txcrb_ctrl_t ctrl,
  input wire logic [txcrb_pkg::MAIN_W-1:0] if_main_divider,
  input wire logic [txcrb_pkg::REF_W-1:0] if_reference_divider,
  input wire logic [txcrb_pkg::TEST_W-1:0] test_control,
  input wire logic lock_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [4:0] quiet_q;
  // Cycles since select low or pin shutdown; registers may move only soon after
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quiet_q <= 5'h00;
    end else if (!serial_pins.cs_n || !power_off_pin_n) begin
      quiet_q <= 5'h00;
    end else if (quiet_q != 5'h1F) begin
      quiet_q <= quiet_q + 5'h01;
    end
  end
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  sequence s_gate_low;
    !transmit_gate_pin [*4];
  endsequence
  sequence s_pin_off;
    !power_off_pin_n [*4];
  endsequence
  sequence s_home;
    if_main_divider == 14'h1977 && if_reference_divider == 11'h1EC && test_control == 8'h00;
  endsequence
  a_reset_home: assert property ($rose(resetn) |-> s_home) else $error("bad power-up values");
  a_pin_off_home: assert property (s_pin_off |-> ##[0:6] s_home) else $error("pin shutdown kept values");
  a_gate_stops_tx: assert property (s_gate_low |-> ##[0:4] (!ctrl.modulator_en && !ctrl.low_band_driver
    && !ctrl.high_band_driver)) else $error("gate pin ignored");
  a_one_driver: assert property (!(ctrl.low_band_driver && ctrl.high_band_driver)) else $error("two drivers");
  a_fm_low_band: assert property (ctrl.fm_mode |-> !ctrl.high_band_driver) else $error("fm on high band");
  a_one_lo_port: assert property (!(ctrl.lo_low_band_input && ctrl.lo_high_band_input))
    else $error("two ports");
  a_regs_on_latch: assert property (($changed(if_main_divider) || $changed(if_reference_divider)
    || $changed(test_control)) |-> quiet_q < 5'h0C) else $error("register moved without latch");
  a_boost_pll: assert property (ctrl.charge_pump_boost |-> ctrl.if_pll_en) else $error("boost without pll");
  a_lock_quiet: assert property ((!pll_lock_raw && test_control == 8'h00 && quiet_q > 5'h08) [*6]
    |-> !lock_pin) else $error("lock pin high without cause");
endmodule
`default_nettype wire

// ---- bench/txcrb_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module txcrb_host (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic data
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    data = 1'b0;
  end
  // Serial clock rests low between frames; data flips after so stale bits never look valid
  task automatic send(input logic [23:0] word);
    int i;
    cs_n <= 1'b0;
    for (i = 23; i >= 0; i--) begin
      data <= word[i];
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    data <= ~word[0];
  endtask
endmodule
`default_nettype wire

// ---- rtl/txcrb_bank.sv ----
`timescale 1ns/1ns
`default_nettype none

module txcrb_bank #(
  parameter int SYNC_DEPTH = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire txcrb_pkg::txcrb_serial_t serial_pins,
  input wire logic power_off_pin_n,
  input wire logic transmit_gate_pin,
  input wire logic pll_lock_raw,
  output var txcrb_pkg::txcrb_ctrl_t ctrl,
  output logic [txcrb_pkg::MAIN_W-1:0] if_main_divider,
  output logic [txcrb_pkg::REF_W-1:0] if_reference_divider,
  output logic [txcrb_pkg::TEST_W-1:0] test_control,
  output logic lock_pin
);

  // One stage would let metastable levels reach the edge finders
  if (SYNC_DEPTH < 2) begin
    $error("SYNC_DEPTH must be at least 2");
  end


  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Six asynchronous pins: sclk, cs_n, data, power-off, gate, lock
  localparam int NPINS = 6;
  logic [NPINS-1:0] pins_raw;
  logic [NPINS-1:0] sync_q [SYNC_DEPTH];
  logic [NPINS-1:0] pins_s;

  assign pins_raw = {pll_lock_raw, transmit_gate_pin, power_off_pin_n,
                     serial_pins.data, serial_pins.cs_n, serial_pins.sclk};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SYNC_DEPTH; i++) begin
        sync_q[i] <= 6'h06;
      end
    end else begin
      sync_q[0] <= pins_raw;
      for (int i = 1; i < SYNC_DEPTH; i++) begin
        sync_q[i] <= sync_q[i-1];
      end
    end
  end

  assign pins_s = sync_q[SYNC_DEPTH-1];

  logic sclk_s;
  logic cs_n_s;
  logic data_s;
  logic pin_on_s;
  logic gate_s;
  logic lock_s;

  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign data_s = pins_s[2];
  assign pin_on_s = pins_s[3];
  assign gate_s = pins_s[4];
  assign lock_s = pins_s[5];

  // Previous synchronised levels for edge finding
  logic sclk_prev_q;
  logic cs_prev_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
    end
  end

  logic sclk_rise;
  logic cs_rise;

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign cs_rise = cs_n_s & ~cs_prev_q;

  // ----------------------------------------------------------------
  // Serial shifter and frame sequencer
  // ----------------------------------------------------------------
  txcrb_pkg::txcrb_state_t state_q;
  logic [txcrb_pkg::WORD_BITS-1:0] shift_q;

  // Power-off pin stops the serial bus too, unlike soft shutdown
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= txcrb_pkg::S_IDLE;
    end else if (!pin_on_s) begin
      state_q <= txcrb_pkg::S_IDLE;
    end else begin
      case (state_q)
        txcrb_pkg::S_IDLE: begin
          if (!cs_n_s) begin
            state_q <= txcrb_pkg::S_SHIFT;
          end
        end
        txcrb_pkg::S_SHIFT: begin
          if (cs_rise) begin
            state_q <= txcrb_pkg::S_LATCH;
          end
        end
        txcrb_pkg::S_LATCH: begin
          state_q <= txcrb_pkg::S_IDLE;
        end
        default: begin
          state_q <= txcrb_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Last 24 bits seen win; a short frame leaves older bits in front
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 24'h000000;
    end else if (!pin_on_s) begin
      shift_q <= 24'h000000;
    end else if (!cs_n_s && sclk_rise) begin
      shift_q <= {shift_q[txcrb_pkg::WORD_BITS-2:0], data_s};
    end
  end

  // Address trails the data, so it sits in the low nibble
  txcrb_pkg::txcrb_addr_t wr_addr;
  logic [txcrb_pkg::DATA_BITS-1:0] wr_data;
  logic wr_en;

  assign wr_addr = shift_q[txcrb_pkg::ADDR_BITS-1:0];
  assign wr_data = shift_q[txcrb_pkg::WORD_BITS-1:txcrb_pkg::ADDR_BITS];
  assign wr_en = (state_q == txcrb_pkg::S_LATCH);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [txcrb_pkg::MAIN_W-1:0] main_q;
  logic [txcrb_pkg::REF_W-1:0] ref_q;
  logic [txcrb_pkg::CTRL_W-1:0] op_q;
  logic [txcrb_pkg::CTRL_W-1:0] cfg_q;
  logic [txcrb_pkg::TEST_W-1:0] test_q;
  logic soft_off;
  logic soft_off_wr;

  assign soft_off = ~op_q[txcrb_pkg::OP_SOFT_POWER_OFF_PIN_N];
  assign soft_off_wr = wr_en && (wr_addr == txcrb_pkg::ADDR_OP_CTRL)
                       && !wr_data[txcrb_pkg::OP_SOFT_POWER_OFF_PIN_N];

  // Soft shutdown returns the control word to power-up except bit 0,
  // else the part would wake itself at once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_q <= txcrb_pkg::OP_CTRL_RESET;
    end else if (!pin_on_s) begin
      op_q <= txcrb_pkg::OP_CTRL_RESET;
    end else if (soft_off_wr) begin
      op_q <= txcrb_pkg::OP_CTRL_RESET & 16'hFFFE;
    end else if (wr_en && wr_addr == txcrb_pkg::ADDR_OP_CTRL) begin
      op_q <= wr_data[txcrb_pkg::CTRL_W-1:0];
    end
  end

  // Other registers: reset to power-up values by either shutdown, frozen while soft-off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      main_q <= txcrb_pkg::MAIN_DIV_RESET;
      ref_q <= txcrb_pkg::REF_DIV_RESET;
      cfg_q <= txcrb_pkg::SETUP_RESET;
      test_q <= txcrb_pkg::TEST_RESET;
    end else if (!pin_on_s || soft_off_wr || soft_off) begin
      main_q <= txcrb_pkg::MAIN_DIV_RESET;
      ref_q <= txcrb_pkg::REF_DIV_RESET;
      cfg_q <= txcrb_pkg::SETUP_RESET;
      test_q <= txcrb_pkg::TEST_RESET;
    end else if (wr_en) begin
      case (wr_addr)
        txcrb_pkg::ADDR_MAIN_DIV: begin
          main_q <= wr_data[txcrb_pkg::MAIN_W-1:0];
        end
        txcrb_pkg::ADDR_REF_DIV: begin
          ref_q <= wr_data[txcrb_pkg::REF_W-1:0];
        end
        txcrb_pkg::ADDR_SETUP: begin
          cfg_q <= wr_data[txcrb_pkg::CTRL_W-1:0];
        end
        txcrb_pkg::ADDR_TEST: begin
          test_q <= wr_data[txcrb_pkg::TEST_W-1:0];
        end
        default: begin
          main_q <= main_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  function automatic txcrb_pkg::txcrb_ctrl_t decode(
    input logic [txcrb_pkg::CTRL_W-1:0] op,
    input logic [txcrb_pkg::CTRL_W-1:0] cfg,
    input logic pin_on,
    input logic gate,
    input logic lock
  );
    txcrb_pkg::txcrb_ctrl_t c;
    logic [1:0] band;
    logic alive;
    logic awake;
    logic tx_on;
    c = '0;
    band = op[txcrb_pkg::OP_MODE_HI:txcrb_pkg::OP_MODE_LO];
    alive = pin_on & op[txcrb_pkg::OP_SOFT_POWER_OFF_PIN_N];
    awake = alive & op[txcrb_pkg::OP_STANDBY_N];
    // Gate pin and transmit standby act alike on the modulator
    tx_on = awake & op[txcrb_pkg::OP_TX_STANDBY_N] & gate;
    c.bias_en = alive;
    c.lo_low_band_input = tx_on & op[txcrb_pkg::OP_LO_PORT];
    c.lo_high_band_input = tx_on & ~op[txcrb_pkg::OP_LO_PORT];
    c.fm_mode = (band == txcrb_pkg::BAND_FM);
    c.low_band_driver = tx_on & ((band == txcrb_pkg::BAND_CELL) | (band == txcrb_pkg::BAND_FM));
    c.high_band_driver = tx_on & (band == txcrb_pkg::BAND_PCS);
    c.if_gain_trim = op[txcrb_pkg::OP_GAIN_HI:txcrb_pkg::OP_GAIN_LO];
    c.upper_sideband = op[txcrb_pkg::OP_SIDEBAND];
    c.if_lo_buffer_en = awake & op[txcrb_pkg::OP_BUF_EN];
    c.quadrature_mod = op[txcrb_pkg::OP_MODULATION_CHOICE];
    c.modulator_en = tx_on & op[txcrb_pkg::OP_MODULATION_CHOICE];
    c.if_pll_en = awake & cfg[txcrb_pkg::CFG_PLL_OFF_N];
    c.if_vco_en = awake & ~cfg[txcrb_pkg::CFG_EXT_OSC];
    c.external_osc_select = cfg[txcrb_pkg::CFG_EXT_OSC];
    // Boost runs until lock unless held on by software
    c.charge_pump_boost = c.if_pll_en & (op[txcrb_pkg::OP_FAST_PUMP] | ~lock);
    c.baseband_level = cfg[txcrb_pkg::CFG_BB_LEVEL];
    c.lo_div2 = cfg[txcrb_pkg::CFG_LO_DIV2];
    c.charge_pump_current = cfg[txcrb_pkg::CFG_CP_HI:txcrb_pkg::CFG_CP_LO];
    c.detector_polarity = cfg[txcrb_pkg::CFG_DET_POL];
    return c;
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= '0;
    end else begin
      ctrl <= decode(op_q, cfg_q, pin_on_s, gate_s, lock_s);
    end
  end

  // ----------------------------------------------------------------
  // Register view and lock pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      if_main_divider <= txcrb_pkg::MAIN_DIV_RESET;
      if_reference_divider <= txcrb_pkg::REF_DIV_RESET;
      test_control <= txcrb_pkg::TEST_RESET;
    end else begin
      if_main_divider <= main_q;
      if_reference_divider <= ref_q;
      test_control <= test_q;
    end
  end

  // Test mode shows test bit 0; no other test function is modelled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_pin <= 1'b0;
    end else if (cfg_q[txcrb_pkg::CFG_LOCK_SEL]) begin
      lock_pin <= lock_s & ctrl.if_pll_en;
    end else begin
      lock_pin <= test_q[0];
    end
  end

endmodule

`default_nettype wire

// ---- rtl/txcrb_pkg.sv ----
package txcrb_pkg;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 24;
  localparam int DATA_BITS = 20;
  localparam int ADDR_BITS = 4;

  typedef logic [ADDR_BITS-1:0] txcrb_addr_t;

  // ----------------------------------------------------------------
  // Register addresses, widths and power-up values
  // ----------------------------------------------------------------
  localparam txcrb_addr_t ADDR_MAIN_DIV = 4'h2;
  localparam txcrb_addr_t ADDR_REF_DIV = 4'h3;
  localparam txcrb_addr_t ADDR_OP_CTRL = 4'h4;
  localparam txcrb_addr_t ADDR_SETUP = 4'h5;
  localparam txcrb_addr_t ADDR_TEST = 4'h7;

  localparam int MAIN_W = 14;
  localparam int REF_W = 11;
  localparam int CTRL_W = 16;
  localparam int TEST_W = 8;

  // 6519 and 492 decimal
  localparam logic [MAIN_W-1:0] MAIN_DIV_RESET = 14'h1977;
  localparam logic [REF_W-1:0] REF_DIV_RESET = 11'h1EC;
  localparam logic [CTRL_W-1:0] OP_CTRL_RESET = 16'h892F;
  localparam logic [CTRL_W-1:0] SETUP_RESET = 16'hD03F;
  localparam logic [TEST_W-1:0] TEST_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions: operation_control
  // ----------------------------------------------------------------
  localparam int OP_LO_PORT = 15;
  localparam int OP_FAST_PUMP = 13;
  localparam int OP_MODE_HI = 12;
  localparam int OP_MODE_LO = 11;
  localparam int OP_GAIN_HI = 8;
  localparam int OP_GAIN_LO = 6;
  localparam int OP_SIDEBAND = 5;
  localparam int OP_BUF_EN = 4;
  localparam int OP_MODULATION_CHOICE = 3;
  localparam int OP_STANDBY_N = 2;
  localparam int OP_TX_STANDBY_N = 1;
  localparam int OP_SOFT_POWER_OFF_PIN_N = 0;

  // ----------------------------------------------------------------
  // Field positions: setup_control
  // ----------------------------------------------------------------
  localparam int CFG_PLL_OFF_N = 15;
  localparam int CFG_BB_LEVEL = 12;
  localparam int CFG_LO_DIV2 = 11;
  localparam int CFG_EXT_OSC = 10;
  localparam int CFG_CP_HI = 9;
  localparam int CFG_CP_LO = 8;
  localparam int CFG_DET_POL = 5;
  localparam int CFG_LOCK_SEL = 0;

  // Band mode codes
  localparam logic [1:0] BAND_FM = 2'h0;
  localparam logic [1:0] BAND_CELL = 2'h1;
  localparam logic [1:0] BAND_PCS = 2'h3;

  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_LATCH} txcrb_state_t;

  // Raw serial pins from the host
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic data;
  } txcrb_serial_t;

  // Decoded controls for the analog sections
  typedef struct packed {
    logic lo_low_band_input;
    logic lo_high_band_input;
    logic charge_pump_boost;
    logic fm_mode;
    logic low_band_driver;
    logic high_band_driver;
    logic [2:0] if_gain_trim;
    logic upper_sideband;
    logic if_lo_buffer_en;
    logic quadrature_mod;
    logic modulator_en;
    logic if_vco_en;
    logic if_pll_en;
    logic baseband_level;
    logic lo_div2;
    logic external_osc_select;
    logic [1:0] charge_pump_current;
    logic detector_polarity;
    logic bias_en;
  } txcrb_ctrl_t;

endpackage
